//--- bench/iplf_core_model.sv
// Purpose: Core side that takes the presented request
// Assumes: Samples on the system clock
// Notes: Keeps the last taken source
`timescale 1ns/1ps
`default_nettype none
module iplf_core_model
(
	input wire logic clk_in,
	input wire logic active_in,
	input wire logic [4:0] source_in,
	output logic [4:0] taken_out
);
	always_ff @(posedge clk_in)
		if (active_in)
			taken_out <= source_in;
endmodule
`default_nettype wire

//--- bench/iplf_monitor.sv
// Purpose: Port checker for the priority fields
// Assumes: One clock domain
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module iplf_monitor
(
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic [4:0] ADDR_IN,
	input wire logic RD_STB_IN,
	input wire logic [15:0] RD_DATA_OUT,
	input wire logic [18:0] SRC_REQ_IN,
	input wire logic LOW_POWER_IN,
	input wire logic IRQ_ACTIVE_OUT,
	input wire logic [1:0] IRQ_LEVEL_OUT,
	input wire logic [4:0] IRQ_SOURCE_OUT,
	input wire logic WAKE_REQ_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	logic [18:0] req_q;
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
		if (SYS_RST_IN)
			req_q <= '0;
		else
			req_q <= SRC_REQ_IN;
	unmapped_zero_a: assert property (RD_STB_IN && ADDR_IN > 5'h03 |=> !RD_DATA_OUT)
		else $error("unmapped read");
	odd_rsvd_a: assert property (RD_STB_IN && ADDR_IN[0] && ADDR_IN < 5'h04
		|=> !(RD_DATA_OUT & 16'h3FC0)) else $error("reserved read");
	two_rsvd_a: assert property (RD_STB_IN && ADDR_IN == 5'h02 |=> !(RD_DATA_OUT & 16'h3C00))
		else $error("reserved read");
	upper_zero_a: assert property (RD_STB_IN && ADDR_IN == 5'h00
		|=> !(RD_DATA_OUT & 16'hFC00)) else $error("upper bits read");
	reset_idle_a: assert property ($past(SYS_RST_IN) |-> !IRQ_ACTIVE_OUT && !WAKE_REQ_OUT)
		else $error("active after reset");
	dbg_level_a: assert property (IRQ_ACTIVE_OUT && IRQ_SOURCE_OUT < 5'h05 |-> IRQ_LEVEL_OUT)
		else $error("debug level 0");
	periph_level_a: assert property (IRQ_ACTIVE_OUT && IRQ_SOURCE_OUT > 5'h04
		|-> IRQ_LEVEL_OUT != 2'h3) else $error("peripheral level 3");
	src_request_a: assert property (IRQ_ACTIVE_OUT |-> req_q[IRQ_SOURCE_OUT])
		else $error("source not requesting");
	wake_cause_a: assert property (WAKE_REQ_OUT |-> $past(LOW_POWER_IN) && req_q)
		else $error("wake without cause");
	cover property (IRQ_ACTIVE_OUT && IRQ_LEVEL_OUT == 2'h3);
	cover property (WAKE_REQ_OUT);
	cover property (RD_STB_IN && ADDR_IN > 5'h03);
endmodule
bind iplf_top iplf_monitor iplf_monitor_inst (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
	.ADDR_IN(ADDR_IN), .RD_STB_IN(RD_STB_IN), .RD_DATA_OUT(RD_DATA_OUT),
	.SRC_REQ_IN(SRC_REQ_IN), .LOW_POWER_IN(LOW_POWER_IN), .IRQ_ACTIVE_OUT(IRQ_ACTIVE_OUT),
	.IRQ_LEVEL_OUT(IRQ_LEVEL_OUT), .IRQ_SOURCE_OUT(IRQ_SOURCE_OUT), .WAKE_REQ_OUT(WAKE_REQ_OUT));
`default_nettype wire

//--- bench/test_irq_priority_level_fields.sv
// Purpose: Register and request tests
// Assumes: Debug fields at index 0
// Notes: Every code swept over every source
`timescale 1ns/1ps
`default_nettype none
module test_irq_priority_level_fields;
	logic clk = 0, rst = 1, wr = 0, rd = 0, lp = 0;
	logic [4:0] adr = '0;
	logic [15:0] wd = '0;
	logic [18:0] req = '0;
	wire logic [15:0] rdat;
	wire logic act, wake;
	wire logic [1:0] lvl;
	wire logic [4:0] src, taken;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	int sh[19] = '{0, 2, 4, 6, 8, 0, 2, 4, 14, 0, 2, 4, 6, 8, 14, 0, 2, 4, 14};
	iplf_top iplf_top_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(adr), .WR_DATA_IN(wd),
		.WR_STB_IN(wr), .RD_STB_IN(rd), .RD_DATA_OUT(rdat), .SRC_REQ_IN(req), .LOW_POWER_IN(lp),
		.IRQ_ACTIVE_OUT(act), .IRQ_LEVEL_OUT(lvl), .IRQ_SOURCE_OUT(src), .WAKE_REQ_OUT(wake));
	iplf_core_model iplf_core_model_inst (.clk_in(clk), .active_in(act), .source_in(src),
		.taken_out(taken));
	initial forever #2 clk = ~clk;
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		tests_run++;
		if (e !== s)
		begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task end_of_test;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rd_data", e, rdat);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
	initial
	begin
		int i, k, l;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 4; i++)
			rd_reg(i[4:0], 16'h0000);
		for (i = 0; i < 6; i++)
			wr_reg(i[4:0], 16'hFFFF);
		rd_reg(5'h00, 16'h03FF);
		rd_reg(5'h01, 16'hC03F);
		rd_reg(5'h02, 16'hC3FF);
		rd_reg(5'h03, 16'hC03F);
		rd_reg(5'h05, 16'h0000);
		for (i = 0; i < 19; i++)
			for (k = 0; k < 4; k++)
			begin
				l = i < 5 ? 0 : i < 9 ? 1 : i < 15 ? 2 : 3;
				@(posedge clk);
				req <= 19'h1 << i;
				wr_reg(l[4:0], 16'(k) << sh[i]);
				repeat (2) @(posedge clk);
				#1 chk("active", k != 0, act);
				chk("level", k == 0 ? 0 : i < 5 ? k : k - 1, lvl);
				chk("source", k == 0 ? 0 : i, src);
			end
		chk("taken", 16'h0012, taken);
		@(posedge clk);
		req <= '0;
		wr_reg(5'h02, 16'h0030);
		lp <= 1'b1;
		wr_reg(5'h00, 16'h0003);
		req <= 19'h1;
		repeat (3) @(posedge clk);
		#1 chk("wake_late", 0, wake);
		@(posedge clk);
		req <= 19'h800;
		repeat (3) @(posedge clk);
		#1 chk("wake", 1, wake);
		chk("fast_level", 2, lvl);
		chk("fast_source", 11, src);
		@(posedge clk);
		req <= 19'h801;
		repeat (2) @(posedge clk);
		#1 chk("win_level", 3, lvl);
		chk("win_source", 0, src);
		// Mid-run reset with requests still up: fields must come back disabled
		@(posedge clk);
		lp <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 4; i++)
			rd_reg(i[4:0], 16'h0000);
		chk("active_reset", 0, act);
		chk("wake_reset", 0, wake);
		end_of_test();
	end
endmodule
`default_nettype wire

//--- design/iplf_pkg.sv
// Purpose: Shared constants for the interrupt priority level fields block
// Assumes: Registers are 16 bits wide, addressed by word index
// Notes: Reserved bits are never stored, so they always read as zero
package iplf_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int FIELD_W = 2;
	localparam int NUM_SRC = 19;
	localparam int NUM_DBG = 5;
	localparam int SRC_IDX_W = 5;

	// Register indices
	localparam logic [4:0] PRIO_REG_ZERO_IDX = 5'h00;
	localparam logic [4:0] PRIO_REG_ONE_IDX = 5'h01;
	localparam logic [4:0] PRIO_REG_TWO_IDX = 5'h02;
	localparam logic [4:0] PRIO_REG_THREE_IDX = 5'h03;

	// Writable bits; everything else is reserved or outside this block
	localparam logic [15:0] PRIO_REG_ZERO_MASK = 16'h03FF;
	localparam logic [15:0] PRIO_REG_ONE_MASK = 16'hC03F;
	localparam logic [15:0] PRIO_REG_TWO_MASK = 16'hC3FF;
	localparam logic [15:0] PRIO_REG_THREE_MASK = 16'hC03F;

	localparam logic [15:0] PRIO_REG_RESET = 16'h0000;
	localparam logic [15:0] READ_ZERO = 16'h0000;

	// Field encodings
	localparam logic [1:0] FIELD_DISABLED = 2'h0;
	localparam logic [1:0] PERIPH_LEVEL_OFFSET = 2'h1;
	localparam logic [1:0] LEVEL_ZERO = 2'h0;
	localparam logic [4:0] SRC_NONE = 5'h00;

	// Field positions: lowest bit of each two-bit level field
	localparam int DBG_STEP_LSB = 32'h0;
	localparam int DBG_BREAK_LSB = 32'h2;
	localparam int DBG_TRACE_LSB = 32'h4;
	localparam int DBG_TX_LSB = 32'h6;
	localparam int DBG_RX_LSB = 32'h8;
	localparam int FLASH_ERR_LSB = 32'h0;
	localparam int FLASH_DONE_LSB = 32'h2;
	localparam int FLASH_BUF_LSB = 32'h4;
	localparam int GPIO_D_LSB = 32'hE;
	localparam int GPIO_C_LSB = 32'h0;
	localparam int GPIO_B_LSB = 32'h2;
	localparam int GPIO_A_LSB = 32'h4;
	localparam int SPI_RX_LSB = 32'h6;
	localparam int SPI_TX_LSB = 32'h8;
	localparam int SER_TX_EMPTY_LSB = 32'hE;
	localparam int SER_TX_IDLE_LSB = 32'h0;
	localparam int SER_RX_ERR_LSB = 32'h2;
	localparam int SER_RX_FULL_LSB = 32'h4;
	localparam int I2C_ERR_LSB = 32'hE;
endpackage

//--- design/iplf_top.sv
// Purpose: Priority level fields for debug and peripheral interrupt sources
// Assumes: Request lines and low-power mode input are on CLK_IN
// Notes: Picks the highest enabled level; lowest source index breaks ties
// Notes on behaviour
// RULE_01 - Debug fields: 00 off, else levels 1-3
// RULE_02 - Peripheral fields: 00 off, else levels 0-2
// RULE_03 - Reset clears every field to disabled
// RULE_04 - Reserved bits written zero, read zero
// RULE_05 - Debug fields at bits 9-0, first register
// RULE_06 - Second register: GPIO D, flash fields
// RULE_07 - Third register: serial, SPI, GPIO A-C
// RULE_08 - Fourth register: I2C error, serial receive/idle
// RULE_09 - Fast interrupts need level 2 programmed
// RULE_10 - Low-power wake only for previously enabled sources
// RULE_11 - Disabled sources never arbitrate or present
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module iplf_top
(
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	// Register port
	input wire logic [iplf_pkg::ADDR_W-1:0] ADDR_IN,
	input wire logic [iplf_pkg::DATA_W-1:0] WR_DATA_IN,
	input wire logic WR_STB_IN,
	input wire logic RD_STB_IN,
	output logic [iplf_pkg::DATA_W-1:0] RD_DATA_OUT,
	// Interrupt sources and low-power mode
	input wire logic [iplf_pkg::NUM_SRC-1:0] SRC_REQ_IN,
	input wire logic LOW_POWER_IN,
	// To core and system integration
	output logic IRQ_ACTIVE_OUT,
	output logic [iplf_pkg::FIELD_W-1:0] IRQ_LEVEL_OUT,
	output logic [iplf_pkg::SRC_IDX_W-1:0] IRQ_SOURCE_OUT,
	output logic WAKE_REQ_OUT
);
	logic [15:0] prio_reg_zero_q;
	logic [15:0] prio_reg_one_q;
	logic [15:0] prio_reg_two_q;
	logic [15:0] prio_reg_three_q;
	logic [15:0] rd_data_q;
	logic [15:0] rd_data_d;
	logic irq_active_q;
	logic [1:0] irq_level_q;
	logic [4:0] irq_source_q;
	logic wake_q;
	logic wake_d;
	logic low_power_q;
	logic [iplf_pkg::NUM_SRC-1:0] wake_mask_q;
	logic [iplf_pkg::NUM_SRC-1:0] wake_mask_d;

	wire wr_zero = WR_STB_IN && (ADDR_IN == iplf_pkg::PRIO_REG_ZERO_IDX);
	wire wr_one = WR_STB_IN && (ADDR_IN == iplf_pkg::PRIO_REG_ONE_IDX);
	wire wr_two = WR_STB_IN && (ADDR_IN == iplf_pkg::PRIO_REG_TWO_IDX);
	wire wr_three = WR_STB_IN && (ADDR_IN == iplf_pkg::PRIO_REG_THREE_IDX);

	// Masking on write keeps reserved bits at zero for reads
	wire [15:0] zero_wdata = WR_DATA_IN & iplf_pkg::PRIO_REG_ZERO_MASK; // RULE_04
	wire [15:0] one_wdata = WR_DATA_IN & iplf_pkg::PRIO_REG_ONE_MASK; // RULE_04
	wire [15:0] two_wdata = WR_DATA_IN & iplf_pkg::PRIO_REG_TWO_MASK; // RULE_04
	wire [15:0] three_wdata = WR_DATA_IN & iplf_pkg::PRIO_REG_THREE_MASK; // RULE_04

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			prio_reg_zero_q <= iplf_pkg::PRIO_REG_RESET; // RULE_03
			prio_reg_one_q <= iplf_pkg::PRIO_REG_RESET; // RULE_03
			prio_reg_two_q <= iplf_pkg::PRIO_REG_RESET; // RULE_03
			prio_reg_three_q <= iplf_pkg::PRIO_REG_RESET; // RULE_03
		end
		else
		begin
			if (wr_zero)
				prio_reg_zero_q <= zero_wdata;
			if (wr_one)
				prio_reg_one_q <= one_wdata;
			if (wr_two)
				prio_reg_two_q <= two_wdata;
			if (wr_three)
				prio_reg_three_q <= three_wdata;
		end
	end

	// Read path; unmapped indices read zero
	always_comb
	begin
		rd_data_d = iplf_pkg::READ_ZERO;
		if (RD_STB_IN)
		begin
			case (ADDR_IN)
				iplf_pkg::PRIO_REG_ZERO_IDX: rd_data_d = prio_reg_zero_q;
				iplf_pkg::PRIO_REG_ONE_IDX: rd_data_d = prio_reg_one_q;
				iplf_pkg::PRIO_REG_TWO_IDX: rd_data_d = prio_reg_two_q;
				iplf_pkg::PRIO_REG_THREE_IDX: rd_data_d = prio_reg_three_q;
				default: rd_data_d = iplf_pkg::READ_ZERO;
			endcase
		end
	end

	// Debug fields, first register
	wire [1:0] debug_step_counter_level =
		prio_reg_zero_q[iplf_pkg::DBG_STEP_LSB +: iplf_pkg::FIELD_W]; // RULE_05
	wire [1:0] debug_breakpoint_level =
		prio_reg_zero_q[iplf_pkg::DBG_BREAK_LSB +: iplf_pkg::FIELD_W]; // RULE_05
	wire [1:0] debug_trace_buffer_level =
		prio_reg_zero_q[iplf_pkg::DBG_TRACE_LSB +: iplf_pkg::FIELD_W]; // RULE_05
	wire [1:0] debug_tx_empty_level =
		prio_reg_zero_q[iplf_pkg::DBG_TX_LSB +: iplf_pkg::FIELD_W]; // RULE_05
	wire [1:0] debug_rx_full_level =
		prio_reg_zero_q[iplf_pkg::DBG_RX_LSB +: iplf_pkg::FIELD_W]; // RULE_05
	// Second register
	wire [1:0] flash_error_level =
		prio_reg_one_q[iplf_pkg::FLASH_ERR_LSB +: iplf_pkg::FIELD_W]; // RULE_06
	wire [1:0] flash_cmd_done_level =
		prio_reg_one_q[iplf_pkg::FLASH_DONE_LSB +: iplf_pkg::FIELD_W]; // RULE_06
	wire [1:0] flash_buffers_empty_level =
		prio_reg_one_q[iplf_pkg::FLASH_BUF_LSB +: iplf_pkg::FIELD_W]; // RULE_06
	wire [1:0] gpio_port_d_level =
		prio_reg_one_q[iplf_pkg::GPIO_D_LSB +: iplf_pkg::FIELD_W]; // RULE_06
	// Third register
	wire [1:0] gpio_port_c_level =
		prio_reg_two_q[iplf_pkg::GPIO_C_LSB +: iplf_pkg::FIELD_W]; // RULE_07
	wire [1:0] gpio_port_b_level =
		prio_reg_two_q[iplf_pkg::GPIO_B_LSB +: iplf_pkg::FIELD_W]; // RULE_07
	wire [1:0] gpio_port_a_level =
		prio_reg_two_q[iplf_pkg::GPIO_A_LSB +: iplf_pkg::FIELD_W]; // RULE_07
	wire [1:0] spi_rx_full_level =
		prio_reg_two_q[iplf_pkg::SPI_RX_LSB +: iplf_pkg::FIELD_W]; // RULE_07
	wire [1:0] spi_tx_empty_level =
		prio_reg_two_q[iplf_pkg::SPI_TX_LSB +: iplf_pkg::FIELD_W]; // RULE_07
	wire [1:0] serial_tx_empty_level =
		prio_reg_two_q[iplf_pkg::SER_TX_EMPTY_LSB +: iplf_pkg::FIELD_W]; // RULE_07
	// Fourth register
	wire [1:0] serial_tx_idle_level =
		prio_reg_three_q[iplf_pkg::SER_TX_IDLE_LSB +: iplf_pkg::FIELD_W]; // RULE_08
	wire [1:0] serial_rx_error_level =
		prio_reg_three_q[iplf_pkg::SER_RX_ERR_LSB +: iplf_pkg::FIELD_W]; // RULE_08
	wire [1:0] serial_rx_full_level =
		prio_reg_three_q[iplf_pkg::SER_RX_FULL_LSB +: iplf_pkg::FIELD_W]; // RULE_08
	wire [1:0] i2c_error_level =
		prio_reg_three_q[iplf_pkg::I2C_ERR_LSB +: iplf_pkg::FIELD_W]; // RULE_08

	// Source index order matches SRC_REQ_IN bit order
	wire [2*iplf_pkg::NUM_SRC-1:0] field_flat = {
		i2c_error_level, serial_rx_full_level, serial_rx_error_level,
		serial_tx_idle_level, serial_tx_empty_level, spi_tx_empty_level,
		spi_rx_full_level, gpio_port_a_level, gpio_port_b_level,
		gpio_port_c_level, gpio_port_d_level, flash_buffers_empty_level,
		flash_cmd_done_level, flash_error_level, debug_rx_full_level,
		debug_tx_empty_level, debug_trace_buffer_level,
		debug_breakpoint_level, debug_step_counter_level};

	logic [iplf_pkg::NUM_SRC-1:0] src_enabled;
	logic [iplf_pkg::NUM_SRC-1:0] src_live;
	logic [1:0] src_level [iplf_pkg::NUM_SRC];

	genvar gi;
	generate
		for (gi = 0; gi < iplf_pkg::NUM_SRC; gi++)
		begin : g_src
			wire [1:0] fld = field_flat[iplf_pkg::FIELD_W*gi +: iplf_pkg::FIELD_W];
			assign src_enabled[gi] = (fld != iplf_pkg::FIELD_DISABLED);
			if (gi < iplf_pkg::NUM_DBG)
			begin : g_dbg
				assign src_level[gi] = fld; // RULE_01
			end
			else
			begin : g_per
				// Level 3 unreachable: code 11 maps to 2
				assign src_level[gi] = fld - iplf_pkg::PERIPH_LEVEL_OFFSET; // RULE_02
			end
			assign src_live[gi] = SRC_REQ_IN[gi] && src_enabled[gi]; // RULE_11
		end
	endgenerate

	// Highest level wins; the strict compare keeps the lowest index on ties
	logic best_vld;
	logic [1:0] best_lvl;
	logic [4:0] best_idx;
	always_comb
	begin
		best_vld = 1'b0;
		best_lvl = iplf_pkg::LEVEL_ZERO;
		best_idx = iplf_pkg::SRC_NONE;
		for (int i = 0; i < iplf_pkg::NUM_SRC; i++)
		begin
			if (src_live[i] && (!best_vld || (src_level[i] > best_lvl))) // RULE_11
			begin
				best_vld = 1'b1;
				best_lvl = src_level[i];
				best_idx = 5'(i);
			end
		end
	end

	// Enable set is frozen on entry, so later writes cannot add wake sources
	wire low_power_entry = LOW_POWER_IN && !low_power_q;
	assign wake_mask_d = low_power_entry ? src_enabled : wake_mask_q; // RULE_10
	assign wake_d = LOW_POWER_IN && low_power_q && |(SRC_REQ_IN & wake_mask_q); // RULE_10

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			rd_data_q <= iplf_pkg::READ_ZERO;
			irq_active_q <= 1'b0;
			irq_level_q <= iplf_pkg::LEVEL_ZERO;
			irq_source_q <= iplf_pkg::SRC_NONE;
			low_power_q <= 1'b0;
			wake_mask_q <= '0;
			wake_q <= 1'b0;
		end
		else
		begin
			rd_data_q <= rd_data_d;
			irq_active_q <= best_vld;
			irq_level_q <= best_lvl;
			irq_source_q <= best_idx;
			low_power_q <= LOW_POWER_IN;
			wake_mask_q <= wake_mask_d;
			wake_q <= wake_d;
		end
	end

	assign RD_DATA_OUT = rd_data_q;
	assign IRQ_ACTIVE_OUT = irq_active_q;
	assign IRQ_LEVEL_OUT = irq_level_q;
	assign IRQ_SOURCE_OUT = irq_source_q;
	assign WAKE_REQ_OUT = wake_q;
endmodule
`default_nettype wire
